// *** src/sdpr_pkg.sv ***
// constants shared by the dual-port ram block: register map and pin layout
package sdpr_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] SDPR_CTRL_OFF   = 8'h00;
  localparam logic [7:0] SDPR_STATUS_OFF = 8'h04;
  localparam logic [7:0] SDPR_CNT0_OFF   = 8'h08;
  localparam logic [7:0] SDPR_CNT1_OFF   = 8'h0C;
  localparam int         SDPR_OFF_W      = 8;
  // ctrl fields: bit p set selects pipelined output on port p
  localparam int          SDPR_CTRL_PIPE_LSB = 0;
  localparam logic [1:0]  SDPR_CTRL_RESET    = 2'h0;
  // status fields: standby of port p at bit p, read pending at bit p+2
  localparam int          SDPR_STAT_STBY_LSB = 0;
  localparam int          SDPR_STAT_RDV_LSB  = 2;
  // axi responses
  localparam logic [1:0]  SDPR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SDPR_RESP_SLVERR = 2'h2;
  // bit positions inside the per-port pin sampling vector
  localparam int SDPR_PIN_CLK    = 0;
  localparam int SDPR_PIN_SEL_LO = 1;
  localparam int SDPR_PIN_SEL_HI = 2;
  localparam int SDPR_PIN_RW     = 3;
  localparam int SDPR_PIN_OE     = 4;
  localparam int SDPR_PIN_LOAD   = 5;
  localparam int SDPR_PIN_ADV    = 6;
  localparam int SDPR_PIN_CLEAR  = 7;
  localparam int SDPR_PIN_ADDR   = 8;
  // documented array sizes
  localparam int SDPR_DATA_W     = 8;
  localparam int SDPR_ADDR_W_BIG = 16;
  localparam int SDPR_ADDR_W_SML = 15;
  localparam int SDPR_PORTS      = 2;
endpackage

// *** src/sdpr_top.sv ***
// dual-port synchronous ram with burst counters and an AXI4-Lite control slave
// What this block does
// - the array holds 64K or 32K bytes, reached from two clocked ports.
// - both ports reach any location, the same one too, with no stall.
// - each port registers address, data and controls on its clock rise.
// - each port picks flow-through or pipelined output from its mode.
// - a port with inactive chip enables at an edge floats and stands by.
// - output enable acts without the port clock; high floats the pins.
// - strobe low with clear high loads the external address and uses it.
// - strobe high, advance low, clear high steps the address up by one.
// - strobe, advance and clear all high reuse the last address.
// - clear low zeroes the counter and uses address zero, always.
// - the counter acts on every port edge, selected or not.
// - pipelined read data arrives one port clock after flow-through.
// - chip enables pass one stage in flow-through, two when pipelined.
// - a write completes in one port clock with no further strobe.
`timescale 1ns/1ns
module sdpr_top
  import sdpr_pkg::*;
#(
  parameter int ADDR_W = SDPR_ADDR_W_BIG
) (
  // system clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // axi4-lite write address
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  // axi4-lite write response
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic [1:0]                          s_axi_bresp,
  // axi4-lite read address
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [31:0]                    s_axi_araddr,
  // axi4-lite read data
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  // memory port pins, index 0 and 1
  input  wire logic [1:0]                     port_clk,
  input  wire logic [1:0]                     select_low_active,
  input  wire logic [1:0]                     select_high_active,
  input  wire logic [1:0]                     read_write,
  input  wire logic [1:0]                     out_enable_n,
  input  wire logic [1:0]                     addr_load_strobe_n,
  input  wire logic [1:0]                     burst_advance_n,
  input  wire logic [1:0]                     burst_clear_n,
  input  wire logic [1:0][ADDR_W-1:0]         addr_pins,
  // data pins, split into three signals
  input  wire logic [1:0][SDPR_DATA_W-1:0]    data_pins_in,
  output logic      [1:0][SDPR_DATA_W-1:0]    data_pins_out,
  output logic      [1:0]                     data_pins_oe
);

  // layout of the sampled pin vector: controls, then address, then data
  localparam int DATA_LSB = SDPR_PIN_ADDR + ADDR_W;
  localparam int SW       = DATA_LSB + SDPR_DATA_W;
  localparam int DEPTH    = 1 << ADDR_W;

  // only the two documented array sizes are served
  if (ADDR_W != SDPR_ADDR_W_BIG && ADDR_W != SDPR_ADDR_W_SML) begin : g_chk
    $error("sdpr_top: ADDR_W must be 15 or 16");
  end

  // the pin vectors are two wide, so the port count is fixed at two
  if (SDPR_PORTS != 2) begin : g_chk_ports
    $error("sdpr_top: two ports expected");
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared state

  // array in flip-flops; the small variant simply has no top address bit;
  // it is never reset, so a word that was never written reads as unknown
  // until a port has written something there; software has no path into it
  logic [SDPR_DATA_W-1:0] mem [DEPTH];
  logic [1:0]             ctrl_pipe;
  logic [1:0]             wr_en;
  logic [ADDR_W-1:0]      wr_addr [SDPR_PORTS];
  logic [SDPR_DATA_W-1:0] wr_data [SDPR_PORTS];
  logic [ADDR_W-1:0]      cnt     [SDPR_PORTS];
  logic [1:0]             standby;
  logic [1:0]             rd_pend;

  // both ports write in the same cycle with no arbitration; on a clash at one
  // address port 1 lands last, which the silicon leaves undefined anyway
  always_ff @(posedge aclk) begin
    for (int p = 0; p < SDPR_PORTS; p++) begin
      if (wr_en[p]) begin
        mem[wr_addr[p]] <= wr_data[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port logic
  // timing per port, in aclk cycles after the port clock pin rises: the
  // rise is counted on the third edge, the write lands and the counter
  // moves on the fourth, flow-through data reaches the pins on the fifth,
  // pipelined data one port clock later; the port clock pin must stay
  // high and low for at least two aclk cycles each, or a rise is lost

  for (genvar g = 0; g < SDPR_PORTS; g++) begin : g_port
    logic [SW-1:0]          s1;
    logic [SW-1:0]          s2;
    logic [SW-1:0]          s3;
    logic                   edge_hit;
    logic                   clk_lvl;
    logic                   sel;
    logic [ADDR_W-1:0]      next_addr;
    logic [SDPR_DATA_W-1:0] rd1;
    logic [SDPR_DATA_W-1:0] rd2;
    logic                   rv1;
    logic                   rv2;
    logic                   sel1;
    logic                   sel2;
    logic                   out_sel;
    logic                   out_rv;

    // pins come from another clock: three stages, s2 feeds s3 and the edge detect
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1 <= '0;
        s2 <= '0;
        s3 <= '0;
      end else begin
        s1 <= {data_pins_in[g], addr_pins[g], burst_clear_n[g],
               burst_advance_n[g], addr_load_strobe_n[g], out_enable_n[g],
               read_write[g], select_high_active[g], select_low_active[g],
               port_clk[g]};
        s2 <= s1;
        s3 <= s2;
      end
    end

    // port clock level as last agreed by stages two and three; it starts
    // low like the parked pin, so leaving reset makes no false rise
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        clk_lvl <= 1'b0;
      end else if (s2[SDPR_PIN_CLK] == s3[SDPR_PIN_CLK]) begin
        clk_lvl <= s3[SDPR_PIN_CLK];
      end
    end

    // a rise counts once stages two and three both show it high; s3 then
    // holds the other pins as they stood while the port clock was high
    assign edge_hit = s2[SDPR_PIN_CLK] & s3[SDPR_PIN_CLK] & ~clk_lvl;
    assign sel      = ~s3[SDPR_PIN_SEL_LO] & s3[SDPR_PIN_SEL_HI];

    // counter next value, clear first, then load, then advance; the wrap
    // at the top of the array is silent, the counter has no carry out
    always_comb begin
      if (!s3[SDPR_PIN_CLEAR]) begin
        next_addr = '0;
      end else if (!s3[SDPR_PIN_LOAD]) begin
        next_addr = s3[SDPR_PIN_ADDR +: ADDR_W];
      end else if (!s3[SDPR_PIN_ADV]) begin
        next_addr = ADDR_W'(cnt[g] + 1'b1);
      end else begin
        next_addr = cnt[g];
      end
    end

    // counter moves on every port edge, chip enables play no part
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt[g] <= '0;
      end else if (edge_hit) begin
        cnt[g] <= next_addr;
      end
    end

    // write is self-timed: lands on the same aclk as the detected edge
    assign wr_en[g]   = edge_hit & sel & ~s3[SDPR_PIN_RW];
    assign wr_addr[g] = next_addr;
    assign wr_data[g] = s3[DATA_LSB +: SDPR_DATA_W];

    // read stages: stage one is flow-through, stage two pipelined; the
    // enables travel through the same stages so deselect takes 1 or 2 edges
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rd1  <= '0;
        rd2  <= '0;
        rv1  <= 1'b0;
        rv2  <= 1'b0;
        sel1 <= 1'b0;
        sel2 <= 1'b0;
      end else if (edge_hit) begin
        rd1  <= mem[next_addr];
        rv1  <= sel & s3[SDPR_PIN_RW];
        sel1 <= sel;
        rd2  <= rd1;
        rv2  <= rv1;
        sel2 <= sel1;
      end
    end

    // each port picks its own stage from its mode bit
    assign out_sel = ctrl_pipe[g] ? sel2 : sel1;
    assign out_rv  = ctrl_pipe[g] ? rv2 : rv1;

    // pin drivers; output enable is looked at every aclk, not per port edge
    // the enable pin is synchronised, so it acts about four aclk after it moves
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        data_pins_out[g] <= '0;
        data_pins_oe[g]  <= 1'b0;
        standby[g]       <= 1'b1;
        rd_pend[g]       <= 1'b0;
      end else begin
        data_pins_out[g] <= ctrl_pipe[g] ? rd2 : rd1;
        data_pins_oe[g]  <= out_sel & out_rv
                            & ~s3[SDPR_PIN_OE];
        standby[g]       <= ~out_sel;
        rd_pend[g]       <= out_sel & out_rv;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  // one write and one read at a time; write address and data may come in
  // either order, and each ready stays low until the response is taken,
  // so a second write simply waits for the first to finish

  logic [SDPR_OFF_W-1:0] aw_off;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  do_write;
  logic [31:0]           next_rdata;
  logic [1:0]            next_rresp;

  // ready low means the channel is held; both held fires the write
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_off        <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_off        <= s_axi_awaddr[SDPR_OFF_W-1:0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // ctrl register and write response; only ctrl is writable
  // a mode change shows the other output stage at once, so software should
  // switch a port's mode only while that port is idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_pipe    <= SDPR_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SDPR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_off == SDPR_CTRL_OFF) begin
        s_axi_bresp <= SDPR_RESP_OKAY;
        if (w_strb[0]) begin
          ctrl_pipe <= w_data[SDPR_CTRL_PIPE_LSB +: 2];
        end
      end else begin
        s_axi_bresp <= SDPR_RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read mux; unmapped offsets answer zero with slverr
  always_comb begin
    next_rdata = '0;
    next_rresp = SDPR_RESP_OKAY;
    unique case (s_axi_araddr[SDPR_OFF_W-1:0])
      SDPR_CTRL_OFF: begin
        next_rdata[SDPR_CTRL_PIPE_LSB +: 2] = ctrl_pipe;
      end
      SDPR_STATUS_OFF: begin
        // both flags follow the output stage, not the input registers
        next_rdata[SDPR_STAT_STBY_LSB +: 2] = standby;
        next_rdata[SDPR_STAT_RDV_LSB +: 2]  = rd_pend;
      end
      SDPR_CNT0_OFF: begin
        next_rdata[ADDR_W-1:0] = cnt[0];
      end
      SDPR_CNT1_OFF: begin
        next_rdata[ADDR_W-1:0] = cnt[1];
      end
      default: begin
        next_rresp = SDPR_RESP_SLVERR;
      end
    endcase
  end

  // read channel: one read in flight, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= SDPR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // sdpr_top

// *** verification/sdpr_top_asserts.sv ***
// concurrent checks on the dual-port ram top-level ports
`timescale 1ns/1ns
module sdpr_asserts (
  // system clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  // axi4-lite handshakes
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [31:0]     s_axi_rdata,
  // memory port pins
  input wire logic [1:0]      port_clk,
  input wire logic [1:0]      out_enable_n,
  input wire logic [1:0][7:0] data_pins_out,
  input wire logic [1:0]      data_pins_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // register slave answers and hold times
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_wr_release: assert property (
    s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write slot not freed");
  a_wr_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  // a released output enable floats the pins with no port clock needed
  a_oe_float0: assert property (
    out_enable_n[0] [*8] |-> !data_pins_oe[0])
    else $error("port 0 drives while disabled");
  a_oe_float1: assert property (
    out_enable_n[1] [*8] |-> !data_pins_oe[1])
    else $error("port 1 drives while disabled");
  // port 0 data moves only in the high phase after a port clock rise,
  // apart from the stage swap that follows a mode write
  a_out_edge: assert property (
    $changed(data_pins_out[0]) && !$past(s_axi_bvalid) |-> port_clk[0])
    else $error("port 0 data moved off edge");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_drive: cover property (data_pins_oe[0] && port_clk[0]);
endmodule // sdpr_asserts
////////////////////////////////////////
bind sdpr_top sdpr_asserts u_sdpr_asserts (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_clk,
  .out_enable_n, .data_pins_out, .data_pins_oe
);

// *** verification/sdpr_host.sv ***
// host controller model pacing one ram port from the system clock
`timescale 1ns/1ns
module sdpr_host (
  // system clock
  input wire logic aclk,
  // pins toward one ram port
  output logic        pclk,
  output logic        sel_n,
  output logic        sel,
  output logic        rw,
  output logic        oe_n,
  output logic        ld_n,
  output logic        adv_n,
  output logic        clr_n,
  output logic [15:0] addr,
  output logic [7:0]  wdata
);
  // idle: clock parked low, port deselected, output enable released
  initial begin
    {pclk, sel_n, sel, rw, oe_n, ld_n, adv_n, clr_n} = 8'h5F;
    addr = 16'h0000;
    wdata = 8'h00;
  end
  ////////////////////////////////////////
  // one port cycle: pins settle 4 aclk before the rise and hold through
  // the whole cycle, so the sampling chain never sees them move
  task cyc(input logic [1:0] ce, input logic r, input logic [2:0] k,
           input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    {sel, sel_n} <= ce; // bank decode
    rw <= r;
    {ld_n, adv_n, clr_n} <= k;
    addr <= a;
    wdata <= r ? ~wdata : d; // no stale byte on reads
    repeat (4) @(posedge aclk);
    pclk <= 1'b1;
    repeat (8) @(posedge aclk);
    pclk <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // output enable level, moved between port cycles
  task set_oe(input logic v);
    @(posedge aclk);
    oe_n <= v;
  endtask
endmodule // sdpr_host

// *** verification/tb_sync_dual_port_ram_port.sv ***
// self-checking bench: axi registers and both ram ports
`timescale 1ns/1ns
module tb_sync_dual_port_ram_port;
  import sdpr_pkg::*;
  // host codes {load_n, advance_n, clear_n}, enables {high, low}
  localparam logic [2:0] LD = 3'h3, ADV = 3'h5, HOLD = 3'h7, CLR = 3'h6;
  localparam logic [1:0] SEL = 2'h2, DSH = 2'h0, DSL = 2'h3;
  localparam logic [1:0] OK = SDPR_RESP_OKAY, ER = SDPR_RESP_SLVERR;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, data_pins_oe;
  logic [31:0] s_axi_rdata;
  logic [1:0][7:0] data_pins_out;
  wire  [1:0]  port_clk, select_low_active, select_high_active, read_write;
  wire  [1:0]  out_enable_n, addr_load_strobe_n, burst_advance_n;
  wire  [1:0]  burst_clear_n;
  wire  [1:0][15:0] addr_pins;
  wire  [1:0][7:0]  data_pins_in;
  int          n_mismatch = 0, samples_checked = 0;

  sdpr_top #(.ADDR_W(SDPR_ADDR_W_BIG)) u_sdpr_top (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .port_clk, .select_low_active,
    .select_high_active, .read_write, .out_enable_n, .addr_load_strobe_n,
    .burst_advance_n, .burst_clear_n, .addr_pins, .data_pins_in,
    .data_pins_out, .data_pins_oe
  );
  // one host controller on each port
  for (genvar p = 0; p < 2; p++) begin : g_host
    sdpr_host u_sdpr_host (
      .aclk, .pclk(port_clk[p]), .sel_n(select_low_active[p]),
      .sel(select_high_active[p]), .rw(read_write[p]),
      .oe_n(out_enable_n[p]), .ld_n(addr_load_strobe_n[p]),
      .adv_n(burst_advance_n[p]), .clr_n(burst_clear_n[p]),
      .addr(addr_pins[p]), .wdata(data_pins_in[p])
    );
  end
  always #20 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // byte and drive flag seen on one port's data pins
  task automatic pin(input int p, input logic [7:0] d, input logic e);
    chk({23'h0, data_pins_oe[p], data_pins_out[p]}, {23'h0, e, d});
  endtask
  task automatic port(input int p, input logic [1:0] c, input logic r,
                      input logic [2:0] k, input logic [15:0] a,
                      input logic [7:0] d);
    if (p == 0) g_host[0].u_sdpr_host.cyc(c, r, k, a, d);
    else g_host[1].u_sdpr_host.cyc(c, r, k, a, d);
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [31:0] a, m, x, input logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, x);
    chk({30'h0, s_axi_rresp}, {30'h0, e});
  endtask
  task automatic summarize;
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SDPR_CTRL_OFF, ALL, 32'h0, OK);
    rd(SDPR_CNT0_OFF, ALL, 32'h0, OK);
    rd(32'h10, ALL, 32'h0, ER);
    wr(SDPR_STATUS_OFF, 32'h1, ER);
    g_host[0].u_sdpr_host.set_oe(1'b0);
    g_host[1].u_sdpr_host.set_oe(1'b0);
    // port 0 burst of writes: load, advance, hold
    port(0, SEL, 1'b0, LD, 16'h0000, 8'h11);
    port(0, SEL, 1'b0, LD, 16'h00FF, 8'hA5);
    port(0, SEL, 1'b0, ADV, 16'h7777, 8'h3C);
    port(0, SEL, 1'b0, HOLD, 16'h1234, 8'hC3);
    rd(SDPR_CNT0_OFF, ALL, 32'h100, OK);
    // deselected cycles still move the counter but write nothing
    port(0, DSH, 1'b0, CLR, 16'h00FF, 8'h77);
    rd(SDPR_CNT0_OFF, ALL, 32'h0, OK);
    rd(SDPR_STATUS_OFF, 32'h1, 32'h1, OK);
    port(0, DSL, 1'b0, LD, 16'h0005, 8'h77);
    rd(SDPR_CNT0_OFF, ALL, 32'h5, OK);
    fork
      port(0, SEL, 1'b1, LD, 16'h0100, 8'h00);
      port(1, SEL, 1'b1, LD, 16'h0100, 8'h00);
    join
    pin(0, 8'hC3, 1'b1);
    pin(1, 8'hC3, 1'b1);
    port(1, SEL, 1'b1, LD, 16'h00FF, 8'h00);
    pin(1, 8'hA5, 1'b1);
    port(1, SEL, 1'b1, CLR, 16'h00FF, 8'h00);
    pin(1, 8'h11, 1'b1);
    port(1, DSL, 1'b1, HOLD, 16'h0000, 8'h00);
    chk({31'h0, data_pins_oe[1]}, 32'h0);
    // port 0 pipelined while port 1 stays flow-through
    wr(SDPR_CTRL_OFF, 32'h1, OK);
    rd(SDPR_CTRL_OFF, ALL, 32'h1, OK);
    port(0, SEL, 1'b1, LD, 16'h00FF, 8'h00);
    pin(0, 8'hC3, 1'b1);
    port(0, SEL, 1'b1, ADV, 16'h0000, 8'h00);
    pin(0, 8'hA5, 1'b1);
    port(0, DSH, 1'b1, HOLD, 16'h0000, 8'h00);
    pin(0, 8'hC3, 1'b1);
    port(0, DSH, 1'b1, HOLD, 16'h0000, 8'h00);
    chk({31'h0, data_pins_oe[0]}, 32'h0);
    // output enable floats and restores port 1 with no port clock
    port(1, SEL, 1'b1, LD, 16'h0000, 8'h00);
    g_host[1].u_sdpr_host.set_oe(1'b1);
    repeat (10) @(posedge aclk);
    chk({31'h0, data_pins_oe[1]}, 32'h0);
    g_host[1].u_sdpr_host.set_oe(1'b0);
    repeat (10) @(posedge aclk);
    pin(1, 8'h11, 1'b1);
    summarize();
  end
  // hang guard, well past the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
endmodule // tb_sync_dual_port_ram_port
